// >>> crt_pkg.sv
// Shared constants and types for the coherency response timing block
// Operation
// RULE_01: Answer every targeted snoop with state response
// RULE_02: State latency counted in processor clock cycles
// RULE_03: Data latency ends at data or bit0
// RULE_04: State response no sooner than five cycles
// RULE_05: Typical state latency per cache divisor
// RULE_06: State response no later than divisor maximum
// RULE_07: Data response no sooner than eight cycles
// RULE_08: Typical data latency per cache divisor
// RULE_09: Data response no later than divisor maximum
// RULE_10: Data figures hold for 32-word blocks
// RULE_11: MRU miss adds up to three cycles
// RULE_12: Bus clock synchronisation adds up to three
// RULE_13: Barriers graduate only while performed input asserted
// RULE_14: Hold barriers while performed input negated
// RULE_15: Agent negates by read/upgrade completion cycle
// RULE_16: Agent negates within two cycles after write
// RULE_17: Sequential consistency may tie input asserted
// RULE_18: Snoops handled strictly in arrival order
// RULE_19: Dirty exclusive hit adds a data response
package crt_pkg;
   localparam int TAG_W = 4;
   localparam int DIV_W = 3;
   localparam int LAT_W = 8;
   localparam int PRC_W = 4;
   localparam int BLOCK_WORDS = 32; // see RULE_10

   typedef logic [LAT_W-1:0] crt_lat_t;

   typedef enum logic [1:0] {
      CRT_INVALID    = 2'b00,
      CRT_SHARED     = 2'b01,
      CRT_CLEAN_EXCL = 2'b10,
      CRT_DIRTY_EXCL = 2'b11
   } crt_coh_t;

   // Cache clock divisor codes 0..4 stand for 1, 1.5, 2, 2.5, 3
   localparam crt_lat_t STATE_MIN_CYC = 8'h05; // see RULE_04
   localparam crt_lat_t DATA_MIN_CYC  = 8'h08; // see RULE_07
   localparam crt_lat_t SYNC_SLACK    = 8'h03; // see RULE_12
   localparam crt_lat_t LRU_EXTRA_MAX = 8'h03; // see RULE_11
   localparam crt_lat_t STATE_TYP [5] =
      '{8'h0A, 8'h0D, 8'h0E, 8'h10, 8'h11}; // see RULE_05
   localparam crt_lat_t STATE_MAX [5] =
      '{8'h27, 8'h30, 8'h3B, 8'h47, 8'h4F}; // see RULE_06
   localparam crt_lat_t DATA_TYP [5] =
      '{8'h1C, 8'h21, 8'h26, 8'h2B, 8'h2B}; // see RULE_08
   localparam crt_lat_t DATA_MAX [5] =
      '{8'h46, 8'h58, 8'h69, 8'h80, 8'h8D}; // see RULE_09
   localparam logic [DIV_W-1:0] DIV_CODE_MAX = 3'h4;

   // Deadline in core cycles; unknown codes take the slowest setting
   function automatic crt_lat_t crt_limit(input logic data,
                                          input logic [DIV_W-1:0] div);
      logic [DIV_W-1:0] d;
      d = (div > DIV_CODE_MAX) ? DIV_CODE_MAX : div;
      crt_limit = (data ? DATA_MAX[d] : STATE_MAX[d]) - SYNC_SLACK;
   endfunction
endpackage

// >>> crt_link_if.sv
// Link between the processor end and the external agent end
interface crt_link_if;
   import crt_pkg::*;
   logic             bus_clk;
   logic             snoop_valid;
   logic [TAG_W-1:0] snoop_tag;
   logic             snoop_busy;
   logic [2:0]       snoop_state_bus;
   logic             snoop_rsp_valid;
   logic             data_grant_n;
   logic             data_valid;
   logic [TAG_W-1:0] data_tag;
   logic             globally_performed_n;

   modport device (
      input  bus_clk, snoop_valid, snoop_tag, data_grant_n,
             globally_performed_n,
      output snoop_busy, snoop_state_bus, snoop_rsp_valid, data_valid,
             data_tag
   );
   modport agent (
      output bus_clk, snoop_valid, snoop_tag, data_grant_n,
             globally_performed_n,
      input  snoop_busy, snoop_state_bus, snoop_rsp_valid, data_valid,
             data_tag
   );
endinterface

// >>> crt_agent.sv
// External agent end: makes the bus clock, issues snoops, drives
// the globally performed level
module crt_agent
   import crt_pkg::*;
#(
   parameter int HALF_DIV = 2
) (
   // Link
   crt_link_if.agent       lnk,
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   // Snoop requests
   input  wire logic             snoop_req,
   input  wire logic [TAG_W-1:0] snoop_req_tag,
   output logic                  snoop_req_ready,
   // Answers
   output logic                  rsp_valid,
   output crt_coh_t              rsp_state,
   output logic                  data_done,
   output logic                  data_by_master,
   // Ordering, and data mastership (device_master)
   input  wire logic             prc_issue,
   input  wire logic             prc_perf,
   input  wire logic             seq_consistent,
   input  wire logic             device_master
);
   typedef struct packed {
      logic [7:0]       dcnt;
      logic             bclk;
      logic             sv;
      logic [TAG_W-1:0] stag;
      logic             gnt_n;
      logic             gp_n;
      logic             pend;
      logic [TAG_W-1:0] ptag;
      logic             open;
      logic             seen_busy;
      logic [1:0]       rv_s;
      logic             rv_p;
      logic [1:0]       dv_s;
      logic [1:0]       di_s;
      logic             dn_p;
      logic [1:0]       bz_s;
      logic [1:0]       sb_s1;
      logic [1:0]       sb_s2;
      logic [PRC_W-1:0] prc_cnt;
      logic             ready;
      logic             rv;
      crt_coh_t         rst;
      logic             dd;
      logic             dm;
   } crt_agent_t;

   crt_agent_t s_reg, s_next;
   logic       fall;
   logic       dn_now;

   always_comb begin
      s_next = s_reg;
      fall   = (s_reg.dcnt == 8'(HALF_DIV - 1)) && s_reg.bclk;
      dn_now = s_reg.dv_s[1] | s_reg.di_s[1];
      // ********************************
      // Bus clock divider
      // ********************************
      if (s_reg.dcnt == 8'(HALF_DIV - 1)) begin
         s_next.dcnt = 8'h00;
         s_next.bclk = ~s_reg.bclk;
      end else begin
         s_next.dcnt = s_reg.dcnt + 8'h01;
      end
      // ********************************
      // Return path, two flops each
      // ********************************
      s_next.rv_s  = {s_reg.rv_s[0], lnk.snoop_rsp_valid};
      s_next.dv_s  = {s_reg.dv_s[0], lnk.data_valid};
      s_next.di_s  = {s_reg.di_s[0], lnk.snoop_state_bus[0]};
      s_next.bz_s  = {s_reg.bz_s[0], lnk.snoop_busy};
      s_next.sb_s1 = lnk.snoop_state_bus[2:1];
      s_next.sb_s2 = s_reg.sb_s1;
      s_next.rv_p  = s_reg.rv_s[1];
      s_next.dn_p  = dn_now;
      s_next.rv    = s_reg.rv_s[1] & ~s_reg.rv_p;
      s_next.dd    = dn_now & ~s_reg.dn_p;
      if (s_reg.rv_s[1] & ~s_reg.rv_p) begin
         s_next.rst = crt_coh_t'(s_reg.sb_s2);
      end
      if (dn_now & ~s_reg.dn_p) begin
         s_next.dm = s_reg.dv_s[1];
      end
      // ********************************
      // Snoop issue, one at a time
      // ********************************
      if (snoop_req && s_reg.ready) begin
         s_next.pend = 1'b1;
         s_next.ptag = snoop_req_tag;
      end
      if (s_reg.bz_s[1]) begin
         s_next.seen_busy = 1'b1;
      end
      // Busy falls together with the last answer of the snoop
      if (s_reg.open && s_reg.seen_busy && !s_reg.bz_s[1]) begin
         s_next.open      = 1'b0;
         s_next.seen_busy = 1'b0;
      end
      // ********************************
      // Outstanding processor requests
      // ********************************
      if (prc_issue && !prc_perf && s_reg.prc_cnt != '1) begin
         s_next.prc_cnt = s_reg.prc_cnt + 1'b1;
      end else if (prc_perf && !prc_issue && s_reg.prc_cnt != '0) begin
         s_next.prc_cnt = s_reg.prc_cnt - 1'b1;
      end
      // Pins change on the falling bus edge, sampled on the rising one
      if (fall) begin
         s_next.sv    = s_reg.pend;
         s_next.stag  = s_reg.ptag;
         s_next.gnt_n = ~device_master;
         // A pending issue counts at once, well inside one bus cycle
         s_next.gp_n  = ~(seq_consistent ||
                          (s_reg.prc_cnt == '0 && !prc_issue)); // see RULE_15, RULE_16, RULE_17
         if (s_reg.pend) begin
            s_next.pend      = 1'b0;
            s_next.open      = 1'b1;
            s_next.seen_busy = 1'b0;
         end
      end
      s_next.ready = ~s_next.pend & ~s_next.open & ~snoop_req;
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_reg       <= '0;
         s_reg.gnt_n <= 1'b1;
         s_reg.gp_n  <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign lnk.bus_clk              = s_reg.bclk;
   assign lnk.snoop_valid          = s_reg.sv;
   assign lnk.snoop_tag            = s_reg.stag;
   assign lnk.data_grant_n         = s_reg.gnt_n;
   assign lnk.globally_performed_n = s_reg.gp_n;
   assign snoop_req_ready          = s_reg.ready;
   assign rsp_valid                = s_reg.rv;
   assign rsp_state                = s_reg.rst;
   assign data_done                = s_reg.dd;
   assign data_by_master           = s_reg.dm;
endmodule // crt_agent

// >>> crt_device.sv
// Processor end: snoop state and data responses, barrier gating
module crt_device
   import crt_pkg::*;
(
   // Link
   crt_link_if.device      lnk,
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   // Mode pins
   input  wire logic [DIV_W-1:0] cache_clock_divisor,
   // Cache lookup
   output logic                  lookup_req,
   output logic [TAG_W-1:0]      lookup_tag,
   input  wire logic             lookup_done,
   input  wire crt_coh_t         lookup_state,
   input  wire logic             data_ready,
   // Barrier graduation
   input  wire logic             barrier_pending,
   output logic                  barrier_grad,
   // Status
   output logic                  latency_overrun
);
   typedef enum logic [1:0] {
      CS_IDLE = 2'b00,
      CS_LOOK = 2'b01,
      CS_DATA = 2'b10
   } crt_core_st_t;

   // ********************************
   // Link domain state
   // ********************************
   typedef struct packed {
      logic             req_tgl;
      logic [TAG_W-1:0] req_tag;
      logic             busy;
      logic [1:0]       st_s;
      logic             st_seen;
      logic [1:0]       dt_s;
      logic             dt_seen;
      logic [2:0]       sbus;
      logic             rv;
      logic             dv;
      logic [TAG_W-1:0] dtag;
   } crt_link_t;

   // ********************************
   // Core domain state
   // ********************************
   typedef struct packed {
      logic [1:0]       req_s;
      logic             req_seen;
      logic [1:0]       gp_s;
      logic [DIV_W-1:0] div_s1;
      logic [DIV_W-1:0] div_s2;
      crt_core_st_t     st;
      crt_lat_t         cnt;
      logic             got;
      crt_coh_t         coh;
      logic             st_tgl;
      logic             dt_tgl;
      crt_coh_t         rsp_coh;
      logic             rsp_dirty;
      logic [TAG_W-1:0] tag;
      logic             lreq;
      logic             grad;
      logic             ovr;
   } crt_core_t;

   crt_link_t l_reg, l_next;
   crt_core_t c_reg, c_next;
   logic      hit_ready;
   crt_coh_t  hit_coh;

   // ********************************
   // Link side, on the bus clock
   // ********************************
   always_comb begin
      l_next         = l_reg;
      l_next.rv      = 1'b0;
      l_next.dv      = 1'b0;
      l_next.sbus[0] = 1'b0;
      l_next.st_s    = {l_reg.st_s[0], c_reg.st_tgl};
      l_next.dt_s    = {l_reg.dt_s[0], c_reg.dt_tgl};
      // One snoop at a time keeps arrival order
      if (lnk.snoop_valid && !l_reg.busy) begin
         l_next.req_tgl = ~l_reg.req_tgl; // see RULE_18
         l_next.req_tag = lnk.snoop_tag;
         l_next.busy    = 1'b1;
      end
      if (l_reg.st_s[1] != l_reg.st_seen) begin
         l_next.st_seen   = l_reg.st_s[1];
         l_next.sbus[2:1] = c_reg.rsp_coh; // see RULE_01
         l_next.rv        = 1'b1;
         if (!c_reg.rsp_dirty) begin
            l_next.busy = 1'b0;
         end
      // Data waits a bus cycle so it never rides with the state answer
      end else if (l_reg.dt_s[1] != l_reg.dt_seen) begin // see RULE_19
         l_next.dt_seen = l_reg.dt_s[1];
         l_next.busy    = 1'b0;
         // Master drives the data itself, slave flags bit zero
         if (!lnk.data_grant_n) begin
            l_next.dv   = 1'b1; // see RULE_03
            l_next.dtag = c_reg.tag;
         end else begin
            l_next.sbus[0] = 1'b1; // see RULE_03
         end
      end
   end

   always_ff @(posedge lnk.bus_clk or posedge sys_rst) begin
      if (sys_rst) begin
         l_reg <= '0;
      end else begin
         l_reg <= l_next;
      end
   end

   // ********************************
   // Core side, on the processor clock
   // ********************************
   always_comb begin
      c_next        = c_reg;
      c_next.lreq   = 1'b0;
      c_next.ovr    = 1'b0;
      c_next.req_s  = {c_reg.req_s[0], l_reg.req_tgl};
      c_next.gp_s   = {c_reg.gp_s[0], lnk.globally_performed_n};
      c_next.div_s1 = cache_clock_divisor;
      c_next.div_s2 = c_reg.div_s1;
      hit_ready     = c_reg.got | lookup_done;
      hit_coh       = c_reg.got ? c_reg.coh : lookup_state;
      // Negated input blocks graduation; one-cycle pulse every other cycle while pending
      c_next.grad   = barrier_pending & ~c_reg.gp_s[1] &
                      ~c_reg.grad; // see RULE_13, RULE_14
      if (c_reg.cnt != '1) begin
         c_next.cnt = c_reg.cnt + 8'h01; // see RULE_02
      end
      case (c_reg.st)
         CS_IDLE: begin
            c_next.cnt = 8'h00;
            // Request tag is held by the link until it goes idle
            if (c_reg.req_s[1] != c_reg.req_seen) begin
               c_next.req_seen = c_reg.req_s[1];
               c_next.tag      = l_reg.req_tag;
               c_next.lreq     = 1'b1;
               c_next.got      = 1'b0;
               c_next.cnt      = 8'h01;
               c_next.st       = CS_LOOK;
            end
         end
         CS_LOOK: begin
            if (lookup_done && !c_reg.got) begin
               c_next.got = 1'b1;
               c_next.coh = lookup_state;
            end
            if (hit_ready && c_reg.cnt >= STATE_MIN_CYC) begin
               c_next.rsp_coh   = hit_coh; // see RULE_04, RULE_05
               c_next.rsp_dirty = (hit_coh == CRT_DIRTY_EXCL); // see RULE_19
               c_next.st_tgl    = ~c_reg.st_tgl;
               c_next.st        = (hit_coh == CRT_DIRTY_EXCL) ?
                                  CS_DATA : CS_IDLE;
            end else if (c_reg.cnt >= crt_limit(1'b0, c_reg.div_s2)) begin
               // A late lookup is answered Invalid so the bus never hangs
               c_next.rsp_coh   = CRT_INVALID; // see RULE_06
               c_next.rsp_dirty = 1'b0;
               c_next.st_tgl    = ~c_reg.st_tgl;
               c_next.ovr       = 1'b1;
               c_next.st        = CS_IDLE;
            end
         end
         CS_DATA: begin
            if (data_ready && c_reg.cnt >= DATA_MIN_CYC) begin
               c_next.dt_tgl = ~c_reg.dt_tgl; // see RULE_07, RULE_08
               c_next.st     = CS_IDLE;
            end else if (c_reg.cnt >= crt_limit(1'b1, c_reg.div_s2)) begin
               c_next.dt_tgl = ~c_reg.dt_tgl; // see RULE_09
               c_next.ovr    = 1'b1;
               c_next.st     = CS_IDLE;
            end
         end
         default: begin
            c_next.st = CS_IDLE;
         end
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         c_reg      <= '0;
         c_reg.gp_s <= 2'b11;
      end else begin
         c_reg <= c_next;
      end
   end

   assign lnk.snoop_busy      = l_reg.busy;
   assign lnk.snoop_state_bus = l_reg.sbus;
   assign lnk.snoop_rsp_valid = l_reg.rv;
   assign lnk.data_valid      = l_reg.dv;
   assign lnk.data_tag        = l_reg.dtag;
   assign lookup_req          = c_reg.lreq;
   assign lookup_tag          = c_reg.tag;
   assign barrier_grad        = c_reg.grad;
   assign latency_overrun     = c_reg.ovr;
endmodule // crt_device

// >>> crt_checker.sv
// Link checker for the coherency response timing block
module crt_checker
   import crt_pkg::*;
(
   // Link clock and reset
   input logic             bus_clk,
   input logic             sys_rst,
   // Snoop side
   input logic             snoop_valid,
   input logic [TAG_W-1:0] snoop_tag,
   input logic             snoop_busy,
   input logic [2:0]       snoop_state_bus,
   input logic             snoop_rsp_valid,
   // Data side
   input logic             data_grant_n,
   input logic             data_valid,
   input logic [TAG_W-1:0] data_tag
);
   default clocking @(posedge bus_clk); endclocking
   default disable iff (sys_rst);
   logic [TAG_W-1:0] tag_reg;

   // Tag of the snoop in flight; one at a time, so one register will do
   always_ff @(posedge bus_clk or posedge sys_rst) begin
      if (sys_rst) tag_reg <= '0;
      else if (snoop_valid && !snoop_busy) tag_reg <= snoop_tag;
   end

   sequence s_state_wait;
      !snoop_rsp_valid ##1 !snoop_rsp_valid ##[1:30] snoop_rsp_valid;
   endsequence
   sequence s_data_ans;
      ##[1:45] (data_valid || snoop_state_bus[0]);
   endsequence

   a_busy_on_take: assert property (
      snoop_valid && !snoop_busy |=> snoop_busy)
      else $error("snoop not taken");
   a_state_window: assert property (
      $rose(snoop_busy) |-> s_state_wait)
      else $error("state answer outside its window");
   a_rsp_in_busy: assert property (
      snoop_rsp_valid |-> $past(snoop_busy))
      else $error("state answer without a snoop");
   a_rsp_one_cycle: assert property (
      snoop_rsp_valid |=> !snoop_rsp_valid)
      else $error("state answer longer than one cycle");
   a_dirty_data: assert property (
      snoop_rsp_valid && snoop_state_bus[2:1] == CRT_DIRTY_EXCL
      |-> s_data_ans)
      else $error("dirty hit without data answer");
   a_data_if_dirty: assert property (
      data_valid || snoop_state_bus[0]
      |-> snoop_state_bus[2:1] == CRT_DIRTY_EXCL)
      else $error("data answer without dirty state");
   a_master_data: assert property (
      data_valid |-> !data_grant_n && !snoop_state_bus[0])
      else $error("data answer as master without grant");
   a_slave_data: assert property (
      snoop_state_bus[0] |-> data_grant_n ##1 !snoop_state_bus[0])
      else $error("slave data indication wrong");
   a_data_tag: assert property (
      data_valid |-> data_tag == tag_reg ##1 !data_valid)
      else $error("data answer tag or width wrong");
endmodule // crt_checker

// >>> tb_coherency_response_timing.sv
// Self-checking bench for the coherency response timing block
module tb_coherency_response_timing import crt_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic             mclk = 1'b0, sys_rst = 1'b1;
   logic             snoop_req = 1'b0, rsp_valid, data_done;
   logic [TAG_W-1:0] snoop_req_tag = '0, lookup_tag;
   logic             snoop_req_ready, data_by_master, lookup_req;
   crt_coh_t         rsp_state, lookup_state = CRT_INVALID;
   logic             prc_issue = 1'b0, prc_perf = 1'b0;
   logic             seq_consistent = 1'b0, device_master = 1'b0;
   logic [DIV_W-1:0] cache_clock_divisor = '0;
   logic             lookup_done = 1'b0, data_ready = 1'b0;
   logic             barrier_pending = 1'b0, barrier_grad, latency_overrun;
   int               num_errors = 0, num_checks = 0, cyc = 0, ovr = 0;
   int               grads = 0, g0, dv;
   logic [31:0]      seed = 32'hEEACD5B2, r;
   crt_coh_t         exp_q[$];

   crt_link_if lnk ();
   crt_agent #(.HALF_DIV(2)) crt_agent_i (.lnk(lnk), .mclk(mclk),
      .sys_rst(sys_rst), .snoop_req(snoop_req),
      .snoop_req_tag(snoop_req_tag), .snoop_req_ready(snoop_req_ready),
      .rsp_valid(rsp_valid), .rsp_state(rsp_state), .data_done(data_done),
      .data_by_master(data_by_master), .prc_issue(prc_issue),
      .prc_perf(prc_perf), .seq_consistent(seq_consistent),
      .device_master(device_master));
   crt_device crt_device_i (.lnk(lnk), .mclk(mclk), .sys_rst(sys_rst),
      .cache_clock_divisor(cache_clock_divisor), .lookup_req(lookup_req),
      .lookup_tag(lookup_tag), .lookup_done(lookup_done),
      .lookup_state(lookup_state), .data_ready(data_ready),
      .barrier_pending(barrier_pending), .barrier_grad(barrier_grad),
      .latency_overrun(latency_overrun));
   crt_checker crt_checker_i (.bus_clk(lnk.bus_clk), .sys_rst(sys_rst),
      .snoop_valid(lnk.snoop_valid), .snoop_tag(lnk.snoop_tag),
      .snoop_busy(lnk.snoop_busy), .snoop_state_bus(lnk.snoop_state_bus),
      .snoop_rsp_valid(lnk.snoop_rsp_valid),
      .data_grant_n(lnk.data_grant_n), .data_valid(lnk.data_valid),
      .data_tag(lnk.data_tag));

   always #2 mclk = ~mclk;
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      ovr <= ovr + int'(latency_overrun);
      grads <= grads + int'(barrier_grad);
   end

   // ***************************
   // Shared tasks
   // ***************************
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic complete_run();
      $display("Checks %0d mismatches %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // Bounded so a dead link ends the run instead of hanging it
   task automatic wait_for(ref logic sig, input int lim);
      int n;
      n = 0;
      while (sig !== 1'b1) begin
         @(negedge mclk);
         n++;
         if (n > lim) begin
            chk("wait bound", 1, 0);
            complete_run();
         end
      end
   endtask
   // Delays above 30 (lookup) or of 60 and more (data) are withheld on purpose
   task automatic snoop(crt_coh_t st, int ld, int dd);
      logic [TAG_W-1:0] tg;
      crt_coh_t ex;
      int t0, ov0;
      tg = TAG_W'(rnd());
      ex = (ld > 30) ? CRT_INVALID : st;
      exp_q.push_back(ex);
      ov0 = ovr;
      wait_for(snoop_req_ready, 60);
      snoop_req = 1'b1;
      snoop_req_tag = tg;
      @(negedge mclk);
      snoop_req = 1'b0;
      wait_for(lookup_req, 60);
      t0 = cyc;
      chk("lookup_tag", tg, lookup_tag);
      if (ld <= 30) begin
         repeat (ld) @(negedge mclk);
         lookup_done = 1'b1;
         lookup_state = st;
         data_ready = (dd == 0);
         @(negedge mclk);
         lookup_done = 1'b0;
      end
      wait_for(rsp_valid, 300);
      chk("rsp_state", exp_q.pop_front(), rsp_state);
      chk("state_min", 1, cyc - t0 >= 5);
      chk("state_max", 1, cyc - t0 <= STATE_MAX[dv] + 20);
      // Quick lookups: LRU query allowance plus both link crossings
      if (ld <= 3) begin
         chk("typ", 1, cyc - t0 <= STATE_TYP[dv] + 19);
      end
      if (ex == CRT_DIRTY_EXCL) begin
         if (dd < 60) begin
            repeat (dd) @(negedge mclk);
            data_ready = 1'b1;
         end
         wait_for(data_done, 400);
         chk("data_master", device_master, data_by_master);
         chk("data_min", 1, cyc - t0 >= 8);
         chk("data_max", 1, cyc - t0 <= DATA_MAX[dv] + 20);
      end
      data_ready = 1'b0;
      chk("overrun", ld > 30 || (dd >= 60 && ex == CRT_DIRTY_EXCL),
          ovr != ov0);
   endtask
   task automatic pulse(ref logic sig);
      sig = 1'b1;
      @(negedge mclk);
      sig = 1'b0;
      repeat (8) @(negedge mclk);
   endtask

   // ***************************
   // Main sequence
   // ***************************
   initial begin
      repeat (4) @(posedge mclk);
      @(negedge mclk);
      sys_rst = 1'b0;
      // Codes 5..7 must act as the slowest setting
      for (int i = 0; i < 48; i++) begin
         cache_clock_divisor = DIV_W'(i % 8);
         dv = (i % 8 > 4) ? 4 : i % 8;
         r = rnd();
         device_master = r[0];
         repeat (4) @(negedge mclk);
         snoop(crt_coh_t'(2'(i)), (i % 7 == 6) ? 99 : int'(r[4:1]),
               (i % 9 == 8) ? 99 : int'(r[8:5]));
      end
      $display("snoop test done");
      pulse(prc_issue);
      chk("gp_negated", 1, lnk.globally_performed_n);
      barrier_pending = 1'b1;
      g0 = grads;
      repeat (30) @(negedge mclk);
      chk("grad_held", g0, grads);
      pulse(prc_perf);
      chk("gp_asserted", 0, lnk.globally_performed_n);
      g0 = grads;
      repeat (20) @(negedge mclk);
      chk("grad_runs", 1, grads - g0 >= 9 && grads - g0 <= 10);
      seq_consistent = 1'b1;
      pulse(prc_issue);
      g0 = grads;
      repeat (20) @(negedge mclk);
      chk("grad_seq", 1, grads > g0);
      barrier_pending = 1'b0;
      $display("barrier test done");
      complete_run();
   end
endmodule // tb_coherency_response_timing
